// ===== src/ddr_cmd_timer.sv
`timescale 1ns/1ns
`default_nettype none
//Contract
// - First write strobe rising edge 0.72 to 1.28 periods after write.
// - Write strobe high and low each at least 0.35 periods.
// - Write strobe falling edges at least 0.2 periods from clock edges.
// - Strobe driven valid no later than the edge starting the preamble.
// - At least 2 cycles after mode register set before next command.
// - Bank open between 40 ns and 70,000 ns before precharge.
// - Activate to activate or refresh on same bank at least 52 ns.
// - Refresh to activate or refresh at least 68 ns.
// - Activate to read or write same bank at least 16 ns.
// - Write with auto precharge waits recovery plus precharge before activate.
// - Activates to different banks at least 8 ns apart.
// - Two cycles from internal write end to a read.
// - Self refresh exit waits 70 ns before a non-read command.
// - Self refresh exit waits 200 cycles before a read.
// - Average refresh interval at most 15.6 microseconds.
// - Never more than eight refreshes owed.
module ddr_cmd_timer #(
	parameter int CAS_LAT_X2 = 6,
	parameter bit FAST_GRADE = 1'b1,
	parameter int BURST_LEN = 4,
	parameter int ADDR_W = 12,
	parameter int AP_BIT = 10,
	parameter int TRAS_MAX_CYC = ddr_timing_pkg::TRAS_MAX_CYC
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic cmd_valid_i,
	input wire ddr_timing_pkg::cmd_t cmd_i,
	input wire logic [1:0] bank_i,
	input wire logic [ADDR_W-1:0] addr_i,
	output logic cmd_ready_o,
	output logic cke_o,
	output logic cs_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic [1:0] ba_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic dqs_oe_o,
	output logic dqs_run_o,
	output logic [3:0] refresh_owed_o,
	output logic [3:0] bank_open_o
);
	localparam int HALF_BL = BURST_LEN / 2;
	localparam int MIN_PS = (CAS_LAT_X2 == 8) ? ddr_timing_pkg::CK_MIN_CL4_PS :
		(CAS_LAT_X2 == 6) ? (FAST_GRADE ? ddr_timing_pkg::CK_MIN_CL3_FAST_PS :
		ddr_timing_pkg::CK_MIN_CL3_SLOW_PS) :
		(CAS_LAT_X2 == 5) ? ddr_timing_pkg::CK_MIN_CL25_PS :
		ddr_timing_pkg::CK_MIN_CL2_PS;
	if (ddr_timing_pkg::CK_PERIOD_PS > ddr_timing_pkg::CK_MAX_PS ||
		ddr_timing_pkg::CK_PERIOD_PS < MIN_PS) begin : g_bad_clk
		$error("clock period outside the range for this latency");
	end
	if ((FAST_GRADE && CAS_LAT_X2 < 6) || CAS_LAT_X2 < 4 || CAS_LAT_X2 > 8 ||
		(!FAST_GRADE && CAS_LAT_X2 == 8)) begin : g_bad_cl
		$error("latency not supported by this grade");
	end
	if (BURST_LEN != 2 && BURST_LEN != 4 && BURST_LEN != 8) begin : g_bad_bl
		$error("burst length must be 2, 4 or 8");
	end
	if (TRAS_MAX_CYC > 16383 ||
		TRAS_MAX_CYC <= ddr_timing_pkg::FORCE_MARGIN_CYC + 8) begin : g_bad_ras
		$error("open-row limit out of range");
	end
	if (AP_BIT >= ADDR_W) begin : g_bad_ap
		$error("auto precharge bit outside address");
	end

	// Counters hold cycles still to wait; a zero count means the spacing is met.
	localparam logic [7:0] L_TRC = 8'(ddr_timing_pkg::TRC_CYC - 1);
	localparam logic [7:0] L_TRCD = 8'(ddr_timing_pkg::TRCD_CYC - 1);
	localparam logic [7:0] L_TRAS = 8'(ddr_timing_pkg::TRAS_MIN_CYC - 1);
	localparam logic [7:0] L_TRP = 8'(ddr_timing_pkg::TRP_CYC - 1);
	localparam logic [7:0] L_ACTIVATE_TO_ACTIVATE_OTHER_BANK = 8'(ddr_timing_pkg::ACTIVATE_TO_ACTIVATE_OTHER_BANK_CYC - 1);
	localparam logic [7:0] L_REFRESH_CYCLE_TIME = 8'(ddr_timing_pkg::REFRESH_CYCLE_TIME_CYC - 1);
	localparam logic [7:0] L_MODE_SET_CYCLE_TIME = 8'(ddr_timing_pkg::MODE_SET_CYCLE_TIME_CYC - 1);
	localparam logic [7:0] L_SELFREFRESH_EXIT_TO_COMMAND = 8'(ddr_timing_pkg::SELFREFRESH_EXIT_TO_COMMAND_CYC - 1);
	localparam logic [7:0] L_SELFREFRESH_EXIT_TO_READ = 8'(ddr_timing_pkg::SELFREFRESH_EXIT_TO_READ_CYC - 1);
	localparam logic [7:0] L_W2P = 8'(ddr_timing_pkg::DQSS_CYC + HALF_BL +
		ddr_timing_pkg::TWR_CYC - 1);
	localparam logic [7:0] L_DAL = 8'(ddr_timing_pkg::DQSS_CYC + HALF_BL +
		ddr_timing_pkg::TWR_CYC + ddr_timing_pkg::TRP_CYC - 1);
	localparam logic [7:0] L_WTR = 8'(ddr_timing_pkg::DQSS_CYC + HALF_BL +
		ddr_timing_pkg::WRITE_TO_READ_DELAY_CYC - 1);
	localparam logic [13:0] AGE_LIMIT = 14'(TRAS_MAX_CYC -
		ddr_timing_pkg::FORCE_MARGIN_CYC);
	localparam logic [13:0] AGE_MAX = 14'(TRAS_MAX_CYC);
	localparam logic [10:0] L_AVERAGE_REFRESH_INTERVAL = 11'(ddr_timing_pkg::AVERAGE_REFRESH_INTERVAL_CYC - 1);
	localparam logic [3:0] OWED_MAX = 4'(ddr_timing_pkg::MAX_OWED);
	localparam logic [3:0] OWED_URGENT = 4'(ddr_timing_pkg::MAX_OWED - 1);
	localparam logic [3:0] L_BURST = 4'(HALF_BL + 1);

	// A load never shortens a wait that is already running.
	function automatic logic [7:0] bump(input logic [7:0] cur,
		input logic [7:0] load);
		logic [7:0] d;
		d = (cur == 8'h00) ? 8'h00 : cur - 8'h01;
		return (load > d) ? load : d;
	endfunction

	function automatic logic [1:0] first_set(input logic [3:0] v);
		return v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
	endfunction

	ddr_timing_pkg::state_t state;
	logic [7:0] act_cnt [4];
	logic [7:0] rcd_cnt [4];
	logic [7:0] pre_cnt [4];
	logic [13:0] age [4];
	logic [3:0] open_b, act_z, rcd_z, pre_z, age_hit, pre_mask, force_pre;
	logic [7:0] mrd_cnt, rrd_cnt, rfc_cnt, wtr_cnt, xsnr_cnt, xsrd_cnt;
	logic [10:0] refi_cnt;
	logic [3:0] owed, wcnt;
	logic urgent, auto_on, ok, issue, idle_all;
	ddr_timing_pkg::cmd_t sel_cmd;
	logic [1:0] sel_bank;
	logic [ADDR_W-1:0] sel_addr;

	assign urgent = (state == ddr_timing_pkg::ST_RUN) && owed >= OWED_URGENT;
	assign force_pre = open_b & (age_hit | {4{urgent}});
	assign auto_on = (force_pre != 4'h0) || (urgent && open_b == 4'h0);
	assign sel_cmd = !auto_on ? cmd_i : (force_pre != 4'h0) ?
		ddr_timing_pkg::CMD_PRE : ddr_timing_pkg::CMD_REF;
	assign sel_bank = auto_on ? first_set(force_pre) : bank_i;
	assign sel_addr = auto_on ? '0 : addr_i;
	assign pre_mask = sel_addr[AP_BIT] ? 4'hF : 4'(1 << sel_bank);
	assign idle_all = open_b == 4'h0 && act_z == 4'hF && rfc_cnt == 8'h00;
	assign issue = ok && (auto_on || cmd_valid_i);
	assign cmd_ready_o = ok && !auto_on;
	assign bank_open_o = open_b;
	assign refresh_owed_o = owed;

	always_comb begin
		ok = 1'b0;
		if (state == ddr_timing_pkg::ST_SELF) begin
			ok = sel_cmd == ddr_timing_pkg::CMD_SRX;
		end else if (mrd_cnt == 8'h00) begin
			unique case (sel_cmd)
				ddr_timing_pkg::CMD_NOP: ok = 1'b1;
				ddr_timing_pkg::CMD_ACT: ok = !open_b[sel_bank] && act_z[sel_bank] &&
					rrd_cnt == 8'h00 && rfc_cnt == 8'h00 && xsnr_cnt == 8'h00;
				ddr_timing_pkg::CMD_RD: ok = open_b[sel_bank] && rcd_z[sel_bank] &&
					wtr_cnt == 8'h00 && xsrd_cnt == 8'h00;
				ddr_timing_pkg::CMD_WR,
				ddr_timing_pkg::CMD_WRA: ok = open_b[sel_bank] && rcd_z[sel_bank] &&
					xsnr_cnt == 8'h00;
				ddr_timing_pkg::CMD_PRE: ok = (pre_mask & ~pre_z) == 4'h0 &&
					xsnr_cnt == 8'h00;
				ddr_timing_pkg::CMD_REF,
				ddr_timing_pkg::CMD_MRS,
				ddr_timing_pkg::CMD_SRE: ok = idle_all && xsnr_cnt == 8'h00;
				ddr_timing_pkg::CMD_SRX: ok = 1'b0;
				default: ok = 1'b0;
			endcase
		end
	end

	for (genvar b = 0; b < 4; b++) begin : g_bank
		logic hit, close;
		assign hit = issue && sel_bank == 2'(b);
		assign close = (issue && sel_cmd == ddr_timing_pkg::CMD_PRE && pre_mask[b]) ||
			(hit && sel_cmd == ddr_timing_pkg::CMD_WRA);
		assign act_z[b] = act_cnt[b] == 8'h00;
		assign rcd_z[b] = rcd_cnt[b] == 8'h00;
		assign pre_z[b] = pre_cnt[b] == 8'h00;
		assign age_hit[b] = age[b] >= AGE_LIMIT;
		always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				act_cnt[b] <= 8'h00;
				rcd_cnt[b] <= 8'h00;
				pre_cnt[b] <= 8'h00;
				open_b[b] <= 1'b0;
				age[b] <= 14'h0000;
			end else begin
				act_cnt[b] <= bump(act_cnt[b],
					(hit && sel_cmd == ddr_timing_pkg::CMD_ACT) ? L_TRC :
					(hit && sel_cmd == ddr_timing_pkg::CMD_WRA) ? L_DAL :
					close ? L_TRP : 8'h00);
				rcd_cnt[b] <= bump(rcd_cnt[b], (hit && sel_cmd ==
					ddr_timing_pkg::CMD_ACT) ? L_TRCD : 8'h00);
				pre_cnt[b] <= bump(pre_cnt[b],
					(hit && sel_cmd == ddr_timing_pkg::CMD_ACT) ? L_TRAS :
					(hit && sel_cmd == ddr_timing_pkg::CMD_WR) ? L_W2P : 8'h00);
				if (hit && sel_cmd == ddr_timing_pkg::CMD_ACT) begin
					open_b[b] <= 1'b1;
					age[b] <= 14'h0000;
				end else if (close) begin
					open_b[b] <= 1'b0;
				end else if (open_b[b] && age[b] != AGE_MAX) begin
					age[b] <= age[b] + 14'h0001;
				end
			end
		end
		a_ras_max: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) open_b[b] |-> age[b] < AGE_MAX) else $error("row open too long");
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mrd_cnt <= 8'h00;
			rrd_cnt <= 8'h00;
			rfc_cnt <= 8'h00;
			wtr_cnt <= 8'h00;
			xsnr_cnt <= 8'h00;
			xsrd_cnt <= 8'h00;
		end else begin
			mrd_cnt <= bump(mrd_cnt, (issue && sel_cmd == ddr_timing_pkg::CMD_MRS) ?
				L_MODE_SET_CYCLE_TIME : 8'h00);
			rrd_cnt <= bump(rrd_cnt, (issue && sel_cmd == ddr_timing_pkg::CMD_ACT) ?
				L_ACTIVATE_TO_ACTIVATE_OTHER_BANK : 8'h00);
			rfc_cnt <= bump(rfc_cnt, (issue && sel_cmd == ddr_timing_pkg::CMD_REF) ?
				L_REFRESH_CYCLE_TIME : 8'h00);
			wtr_cnt <= bump(wtr_cnt, (issue && (sel_cmd == ddr_timing_pkg::CMD_WR ||
				sel_cmd == ddr_timing_pkg::CMD_WRA)) ? L_WTR : 8'h00);
			xsnr_cnt <= bump(xsnr_cnt, (issue && sel_cmd == ddr_timing_pkg::CMD_SRX) ?
				L_SELFREFRESH_EXIT_TO_COMMAND : 8'h00);
			xsrd_cnt <= bump(xsrd_cnt, (issue && sel_cmd == ddr_timing_pkg::CMD_SRX) ?
				L_SELFREFRESH_EXIT_TO_READ : 8'h00);
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= ddr_timing_pkg::ST_RUN;
		end else if (issue && sel_cmd == ddr_timing_pkg::CMD_SRE) begin
			state <= ddr_timing_pkg::ST_SELF;
		end else if (issue && sel_cmd == ddr_timing_pkg::CMD_SRX) begin
			state <= ddr_timing_pkg::ST_RUN;
		end
	end

	// The interval timer stops in self refresh, where the device refreshes itself.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			refi_cnt <= L_AVERAGE_REFRESH_INTERVAL;
			owed <= 4'h0;
		end else if (state == ddr_timing_pkg::ST_RUN) begin
			refi_cnt <= (refi_cnt == 11'h000) ? L_AVERAGE_REFRESH_INTERVAL : refi_cnt - 11'h001;
			if (refi_cnt == 11'h000 && !(issue && sel_cmd == ddr_timing_pkg::CMD_REF)) begin
				owed <= (owed == OWED_MAX) ? OWED_MAX : owed + 4'h1;
			end else if (refi_cnt != 11'h000 && issue &&
				sel_cmd == ddr_timing_pkg::CMD_REF && owed != 4'h0) begin
				owed <= owed - 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cke_o <= 1'b1;
			cs_n_o <= 1'b1;
			{ras_n_o, cas_n_o, we_n_o} <= ddr_timing_pkg::PIN_NOP;
			ba_o <= 2'h0;
			addr_o <= '0;
		end else begin
			cke_o <= (issue && sel_cmd == ddr_timing_pkg::CMD_SRE) ? 1'b0 :
				(issue && sel_cmd == ddr_timing_pkg::CMD_SRX) ? 1'b1 : cke_o;
			cs_n_o <= !issue || sel_cmd == ddr_timing_pkg::CMD_NOP ||
				sel_cmd == ddr_timing_pkg::CMD_SRX;
			ba_o <= sel_bank;
			addr_o <= sel_addr;
			if (issue && (sel_cmd == ddr_timing_pkg::CMD_WR ||
				sel_cmd == ddr_timing_pkg::CMD_WRA)) begin
				addr_o[AP_BIT] <= sel_cmd == ddr_timing_pkg::CMD_WRA;
			end
			unique case (issue ? sel_cmd : ddr_timing_pkg::CMD_NOP)
				ddr_timing_pkg::CMD_ACT: {ras_n_o, cas_n_o, we_n_o} <= ddr_timing_pkg::PIN_ACT;
				ddr_timing_pkg::CMD_RD: {ras_n_o, cas_n_o, we_n_o} <= ddr_timing_pkg::PIN_RD;
				ddr_timing_pkg::CMD_WR,
				ddr_timing_pkg::CMD_WRA: {ras_n_o, cas_n_o, we_n_o} <= ddr_timing_pkg::PIN_WR;
				ddr_timing_pkg::CMD_PRE: {ras_n_o, cas_n_o, we_n_o} <= ddr_timing_pkg::PIN_PRE;
				ddr_timing_pkg::CMD_REF,
				ddr_timing_pkg::CMD_SRE: {ras_n_o, cas_n_o, we_n_o} <= ddr_timing_pkg::PIN_REF;
				ddr_timing_pkg::CMD_MRS: {ras_n_o, cas_n_o, we_n_o} <= ddr_timing_pkg::PIN_MRS;
				default: {ras_n_o, cas_n_o, we_n_o} <= ddr_timing_pkg::PIN_NOP;
			endcase
		end
	end

	// The strobe enable rises with the write on the pins, one cycle of preamble
	// ahead of the toggling, so the first rising strobe lands one full period
	// after the command. The phy toggles at half-period duty, centring falls
	// half a period from each clock edge.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wcnt <= 4'h0;
			dqs_oe_o <= 1'b0;
			dqs_run_o <= 1'b0;
		end else begin
			wcnt <= (issue && (sel_cmd == ddr_timing_pkg::CMD_WR ||
				sel_cmd == ddr_timing_pkg::CMD_WRA)) ? L_BURST :
				(wcnt != 4'h0) ? wcnt - 4'h1 : 4'h0;
			dqs_oe_o <= (issue && (sel_cmd == ddr_timing_pkg::CMD_WR ||
				sel_cmd == ddr_timing_pkg::CMD_WRA)) || wcnt > 4'h1;
			dqs_run_o <= wcnt > 4'h1;
		end
	end

	logic pin_cmd, pin_act, pin_rw, pin_wr, pin_rd, pin_pre, pin_ref, pin_mrs;
	logic [7:0] pin_age [4];
	assign pin_cmd = !cs_n_o;
	assign pin_act = pin_cmd && {ras_n_o, cas_n_o, we_n_o} == ddr_timing_pkg::PIN_ACT;
	assign pin_wr = pin_cmd && {ras_n_o, cas_n_o, we_n_o} == ddr_timing_pkg::PIN_WR;
	assign pin_rd = pin_cmd && {ras_n_o, cas_n_o, we_n_o} == ddr_timing_pkg::PIN_RD;
	assign pin_rw = pin_wr || pin_rd;
	assign pin_pre = pin_cmd && {ras_n_o, cas_n_o, we_n_o} == ddr_timing_pkg::PIN_PRE;
	assign pin_ref = pin_cmd && cke_o &&
		{ras_n_o, cas_n_o, we_n_o} == ddr_timing_pkg::PIN_REF;
	assign pin_mrs = pin_cmd && {ras_n_o, cas_n_o, we_n_o} == ddr_timing_pkg::PIN_MRS;
	for (genvar b = 0; b < 4; b++) begin : g_age
		always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				pin_age[b] <= 8'hFF;
			end else if (pin_act && ba_o == 2'(b)) begin
				pin_age[b] <= 8'h01;
			end else if (pin_age[b] != 8'hFF) begin
				pin_age[b] <= pin_age[b] + 8'h01;
			end
		end
	end

	a_mode_gap: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) pin_mrs |=> cs_n_o) else $error("command too soon after mode set");
	a_rc_same_bank: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) pin_act |-> pin_age[ba_o] >= 8'(ddr_timing_pkg::TRC_CYC)) else $error("same-bank activates too close");
	a_ras_min: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) (pin_pre && !addr_o[AP_BIT]) |-> pin_age[ba_o] >= 8'(ddr_timing_pkg::TRAS_MIN_CYC)) else $error("precharge before row minimum");
	a_act_to_rw: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) pin_rw |-> pin_age[ba_o] >= 8'(ddr_timing_pkg::TRCD_CYC)) else $error("access too soon after activate");
	a_ref_gap: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) pin_ref |=> !(pin_act || pin_ref) [*8]) else $error("refresh spacing broken");
	a_wtr_gap: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) pin_wr |=> !pin_rd [*4]) else $error("read too soon after write");
	a_strobe_start: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) pin_wr |-> dqs_oe_o ##1 (dqs_oe_o && dqs_run_o)) else $error("strobe not started one period after write");
	a_strobe_burst: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) $rose(dqs_run_o) |-> dqs_run_o [*2] ##0 $past(dqs_oe_o)) else $error("strobe burst too short");
	a_owed_bound: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) refresh_owed_o <= OWED_MAX) else $error("too many refreshes owed");
	a_self_exit: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) $rose(cke_o) |-> cs_n_o [*8]) else $error("command too soon after self refresh");

	c_write_ap: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) pin_wr && addr_o[AP_BIT]);
	c_refresh: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) pin_ref);
	c_self_exit: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) $rose(cke_o));
	c_urgent: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) urgent && auto_on);
endmodule
`default_nettype wire

// ===== src/ddr_timing_pkg.sv
package ddr_timing_pkg;
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_ACT = 4'h1,
		CMD_RD = 4'h2,
		CMD_WR = 4'h3,
		CMD_WRA = 4'h4,
		CMD_PRE = 4'h5,
		CMD_REF = 4'h6,
		CMD_MRS = 4'h7,
		CMD_SRE = 4'h8,
		CMD_SRX = 4'h9
	} cmd_t;
	typedef enum logic {ST_RUN = 1'h0, ST_SELF = 1'h1} state_t;
	// Pin codes are {ras_n, cas_n, we_n}.
	localparam logic [2:0] PIN_NOP = 3'h7;
	localparam logic [2:0] PIN_ACT = 3'h3;
	localparam logic [2:0] PIN_RD = 3'h5;
	localparam logic [2:0] PIN_WR = 3'h4;
	localparam logic [2:0] PIN_PRE = 3'h2;
	localparam logic [2:0] PIN_REF = 3'h1;
	localparam logic [2:0] PIN_MRS = 3'h0;
	localparam int CK_PERIOD_PS = 8000;
	localparam int CK_MAX_PS = 10000;
	localparam int CK_MIN_CL4_PS = 4000;
	localparam int CK_MIN_CL3_FAST_PS = 5000;
	localparam int CK_MIN_CL3_SLOW_PS = 6000;
	localparam int CK_MIN_CL25_PS = 6000;
	localparam int CK_MIN_CL2_PS = 7500;
	function automatic int ceil_cyc(input int ns);
		int c;
		c = (ns * 1000 + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int TRAS_MIN_NS = 40;
	localparam int TRAS_MAX_NS = 70000;
	localparam int TRC_NS = 52;
	localparam int REFRESH_CYCLE_TIME_NS = 68;
	localparam int TRCD_NS = 16;
	localparam int TRP_NS = 16;
	localparam int TWR_NS = 16;
	localparam int ACTIVATE_TO_ACTIVATE_OTHER_BANK_NS = 8;
	localparam int SELFREFRESH_EXIT_TO_COMMAND_NS = 70;
	localparam int TRAS_MIN_CYC = ceil_cyc(TRAS_MIN_NS);
	localparam int TRAS_MAX_CYC = TRAS_MAX_NS * 1000 / CK_PERIOD_PS;
	localparam int TRC_CYC = ceil_cyc(TRC_NS);
	localparam int REFRESH_CYCLE_TIME_CYC = ceil_cyc(REFRESH_CYCLE_TIME_NS);
	localparam int TRCD_CYC = ceil_cyc(TRCD_NS);
	localparam int TRP_CYC = ceil_cyc(TRP_NS);
	localparam int TWR_CYC = ceil_cyc(TWR_NS);
	localparam int ACTIVATE_TO_ACTIVATE_OTHER_BANK_CYC = ceil_cyc(ACTIVATE_TO_ACTIVATE_OTHER_BANK_NS);
	localparam int SELFREFRESH_EXIT_TO_COMMAND_CYC = ceil_cyc(SELFREFRESH_EXIT_TO_COMMAND_NS);
	localparam int MODE_SET_CYCLE_TIME_CYC = 2;
	localparam int WRITE_TO_READ_DELAY_CYC = 2;
	localparam int SELFREFRESH_EXIT_TO_READ_CYC = 200;
	localparam real AVERAGE_REFRESH_INTERVAL_US = 15.6;
	localparam int AVERAGE_REFRESH_INTERVAL_CYC = $rtoi(AVERAGE_REFRESH_INTERVAL_US * 1000000.0 / CK_PERIOD_PS);
	localparam int MAX_OWED = 8;
	localparam int DQSS_CYC = 1;
	localparam int FORCE_MARGIN_CYC = 16;
endpackage

// ===== verif/ddr_cmd_timer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ddr_cmd_timer_bench;
	typedef struct {
		logic [4:0] pins;
		logic [1:0] ba;
		logic [11:0] addr;
		logic wr;
		logic act;
	} note_t;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i;
	logic cmd_valid_i;
	ddr_timing_pkg::cmd_t cmd_i;
	logic [1:0] bank_i;
	logic [11:0] addr_i;
	logic cmd_ready_o, cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o;
	logic [1:0] ba_o;
	logic [11:0] addr_o;
	logic dqs_oe_o, dqs_run_o;
	logic [3:0] refresh_owed_o, bank_open_o;
	int model_errs;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [31:0] seed;
	bit in_self;
	note_t notes[$];

	always #4 ref_clk_i = ~ref_clk_i;

	ddr_cmd_timer i_ddr_cmd_timer (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.cmd_valid_i(cmd_valid_i),
		.cmd_i(cmd_i),
		.bank_i(bank_i),
		.addr_i(addr_i),
		.cmd_ready_o(cmd_ready_o),
		.cke_o(cke_o),
		.cs_n_o(cs_n_o),
		.ras_n_o(ras_n_o),
		.cas_n_o(cas_n_o),
		.we_n_o(we_n_o),
		.ba_o(ba_o),
		.addr_o(addr_o),
		.dqs_oe_o(dqs_oe_o),
		.dqs_run_o(dqs_run_o),
		.refresh_owed_o(refresh_owed_o),
		.bank_open_o(bank_open_o)
	);

	ddr_dev_model #(
		.TRAS_MAX(ddr_timing_pkg::TRAS_MAX_CYC)
	) i_ddr_dev_model (
		.clk_i(ref_clk_i),
		.rst_i(sys_rst_i),
		.cke_i(cke_o),
		.cs_n_i(cs_n_o),
		.ras_n_i(ras_n_o),
		.cas_n_i(cas_n_o),
		.we_n_i(we_n_o),
		.ba_i(ba_o),
		.addr_i(addr_o),
		.dqs_oe_i(dqs_oe_o),
		.dqs_run_i(dqs_run_o),
		.errs_o(model_errs)
	);

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	// Expected {cke, cs_n, ras_n, cas_n, we_n} one cycle after a taking.
	function automatic logic [4:0] exp_pins(input ddr_timing_pkg::cmd_t c);
		case (c)
			ddr_timing_pkg::CMD_ACT: return {2'h2, ddr_timing_pkg::PIN_ACT};
			ddr_timing_pkg::CMD_RD: return {2'h2, ddr_timing_pkg::PIN_RD};
			ddr_timing_pkg::CMD_WR,
			ddr_timing_pkg::CMD_WRA: return {2'h2, ddr_timing_pkg::PIN_WR};
			ddr_timing_pkg::CMD_PRE: return {2'h2, ddr_timing_pkg::PIN_PRE};
			ddr_timing_pkg::CMD_REF: return {2'h2, ddr_timing_pkg::PIN_REF};
			ddr_timing_pkg::CMD_MRS: return {2'h2, ddr_timing_pkg::PIN_MRS};
			ddr_timing_pkg::CMD_SRE: return {2'h0, ddr_timing_pkg::PIN_REF};
			default: return {2'h3, ddr_timing_pkg::PIN_NOP};
		endcase
	endfunction

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Picks only requests that the current bank state can ever accept, so a
	// held request cannot wait forever on a bank that nobody will open.
	task automatic pick(output ddr_timing_pkg::cmd_t c, output logic [1:0] b,
		output logic [11:0] a);
		b = seed[5:4];
		a = seed[27:16];
		c = ddr_timing_pkg::cmd_t'(seed[31:28] % 4'hA);
		if (in_self) begin
			c = ddr_timing_pkg::CMD_SRX;
		end else begin
			if (c == ddr_timing_pkg::CMD_SRX) begin
				c = ddr_timing_pkg::CMD_NOP;
			end
			if (c == ddr_timing_pkg::CMD_SRE && seed[8:6] != 3'h0) begin
				c = ddr_timing_pkg::CMD_REF;
			end
			if (c == ddr_timing_pkg::CMD_ACT && bank_open_o[b]) begin
				c = ddr_timing_pkg::CMD_PRE;
			end
			if ((c == ddr_timing_pkg::CMD_RD || c == ddr_timing_pkg::CMD_WR ||
				c == ddr_timing_pkg::CMD_WRA || c == ddr_timing_pkg::CMD_PRE) &&
				!bank_open_o[b]) begin
				c = ddr_timing_pkg::CMD_ACT;
			end
			if ((c == ddr_timing_pkg::CMD_REF || c == ddr_timing_pkg::CMD_MRS ||
				c == ddr_timing_pkg::CMD_SRE) && bank_open_o != 4'h0) begin
				c = ddr_timing_pkg::CMD_PRE;
				a[10] = 1'b1;
			end
		end
	endtask

	initial begin
		ddr_timing_pkg::cmd_t c;
		logic [1:0] b;
		logic [11:0] a;
		note_t n;
		sys_rst_i = 1'b1;
		cmd_valid_i = 1'b0;
		cmd_i = ddr_timing_pkg::CMD_NOP;
		bank_i = 2'h0;
		addr_i = 12'h000;
		seed = 32'h9C230BB8;
		in_self = 1'b0;
		repeat (12) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		check("idle pins", {cke_o, cs_n_o}, 32'h3);
		check("owed after reset", refresh_owed_o, 32'h0);
		for (int k = 0; k < 1500; k++) begin
			seed = xorshift(seed);
			pick(c, b, a);
			cmd_valid_i <= 1'b1;
			cmd_i <= c;
			bank_i <= b;
			addr_i <= a;
			do @(posedge ref_clk_i); while (cmd_ready_o !== 1'b1);
			n.pins = exp_pins(c);
			n.ba = b;
			n.addr = a;
			n.wr = c == ddr_timing_pkg::CMD_WR || c == ddr_timing_pkg::CMD_WRA;
			if (n.wr) begin
				n.addr[10] = c == ddr_timing_pkg::CMD_WRA;
			end
			n.act = c == ddr_timing_pkg::CMD_ACT;
			notes.push_back(n);
			if (c == ddr_timing_pkg::CMD_SRE) begin
				in_self = 1'b1;
			end else if (c == ddr_timing_pkg::CMD_SRX) begin
				in_self = 1'b0;
			end
			cmd_valid_i <= 1'b0;
			@(posedge ref_clk_i);
		end
		repeat (4) @(posedge ref_clk_i);
		check("queue drained", notes.size(), 32'h0);
		check("model errors", model_errs, 32'h0);
		check("owed bound", refresh_owed_o <= 4'h8, 32'h1);
		tally_and_finish();
	end

	// Pins are looked at just after the edge that launched them.
	always begin
		note_t n;
		@(posedge ref_clk_i);
		#1;
		if (notes.size() != 0) begin
			n = notes.pop_front();
			check("command pins", {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o},
				n.pins);
			check("bank pins", ba_o, n.ba);
			check("address pins", addr_o, n.addr);
			if (n.wr) begin
				check("strobe enable", dqs_oe_o, 32'h1);
			end
			if (n.act) begin
				check("bank opened", bank_open_o[n.ba], 32'h1);
			end
		end
	end

	// About 15 cycles a command at most, 200 for a read after self refresh exit; the limit leaves ample slack.
	initial begin
		repeat (90000) @(posedge ref_clk_i);
		n_mismatch++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ===== verif/ddr_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module ddr_dev_model #(
	parameter int TRAS_MAX = 8750
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [1:0] ba_i,
	input wire logic [11:0] addr_i,
	input wire logic dqs_oe_i,
	input wire logic dqs_run_i,
	output var int errs_o
);
	localparam int CK_NS = 8;
	// Minimums are rounded up so a fractional cycle is never given away.
	function automatic int cyc_of(input int ns);
		return (ns + CK_NS - 1) / CK_NS;
	endfunction
	localparam int TRAS_MIN = cyc_of(40);
	localparam int ACTIVATE_TO_ACTIVATE_SAME_BANK = cyc_of(52);
	localparam int REFRESH_CYCLE_TIME = cyc_of(68);
	localparam int TRCD = cyc_of(16);
	localparam int PRECHARGE_PERIOD = cyc_of(16);
	localparam int WRITE_RECOVERY = cyc_of(16);
	localparam int ACTIVATE_TO_ACTIVATE_OTHER_BANK = cyc_of(8);
	localparam int SELFREFRESH_EXIT_TO_COMMAND = cyc_of(70);
	localparam int REFI = 15600 / CK_NS;
	int cyc, ref_t, mrs_t, srx_t, wend_t, any_act, wcnt, ticks, refs, tcnt;
	// Write recovery is owed by the bank that was written, not by its neighbours.
	int wb;
	int act_t[4], pre_t[4], dal_t[4];
	bit opn[4];
	bit prev_cke;
	logic [2:0] code;
	realtime t_last;
	task automatic bad(input bit c);
		if (c)
			errs_o++;
	endtask
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			{cyc, errs_o, wcnt, ticks, refs, tcnt, wb} = '0;
			{ref_t, mrs_t, srx_t, wend_t, any_act} = {5{-999}};
			for (int b = 0; b < 4; b++) begin
				act_t[b] = -999;
				pre_t[b] = -999;
				dal_t[b] = -999;
				opn[b] = 1'b0;
			end
			prev_cke = 1'b1;
			t_last = 0;
		end else begin
			cyc++;
			if (t_last > 0)
				bad($realtime - t_last < 4.0 || $realtime - t_last > 10.0);
			t_last = $realtime;
			if (cke_i && !prev_cke)
				srx_t = cyc;
			prev_cke = cke_i;
			if (cke_i && ++tcnt == REFI) begin
				tcnt = 0;
				ticks++;
			end
			bad(ticks - refs > 8);
			if (wcnt > 0) begin
				bad(!dqs_run_i);
				wcnt--;
			end else
				bad(dqs_run_i);
			for (int b = 0; b < 4; b++)
				bad(opn[b] && cyc - act_t[b] > TRAS_MAX);
			code = {ras_n_i, cas_n_i, we_n_i};
			if (!cs_n_i && cke_i) begin
				bad(cyc - mrs_t < 2);
				bad(code != ddr_timing_pkg::PIN_RD && cyc - srx_t < SELFREFRESH_EXIT_TO_COMMAND);
				case (code)
					ddr_timing_pkg::PIN_ACT: begin
						bad(opn[ba_i] || cyc - act_t[ba_i] < ACTIVATE_TO_ACTIVATE_SAME_BANK);
						bad(cyc - ref_t < REFRESH_CYCLE_TIME || cyc - pre_t[ba_i] < PRECHARGE_PERIOD);
						bad(cyc - any_act < ACTIVATE_TO_ACTIVATE_OTHER_BANK || cyc < dal_t[ba_i]);
						opn[ba_i] = 1'b1;
						act_t[ba_i] = cyc;
						any_act = cyc;
					end
					ddr_timing_pkg::PIN_RD, ddr_timing_pkg::PIN_WR: begin
						bad(!opn[ba_i] || cyc - act_t[ba_i] < TRCD);
						if (code == ddr_timing_pkg::PIN_RD)
							bad(cyc - wend_t < 2 || cyc - srx_t < 200);
						else begin
							bad(!dqs_oe_i);
							wend_t = cyc + 3;
							wb = ba_i;
							wcnt = 2;
							if (addr_i[10]) begin
								opn[ba_i] = 1'b0;
								dal_t[ba_i] = wend_t + WRITE_RECOVERY + PRECHARGE_PERIOD;
							end
						end
					end
					ddr_timing_pkg::PIN_PRE:
						for (int b = 0; b < 4; b++)
							if (opn[b] && (addr_i[10] || b == ba_i)) begin
								bad(cyc - act_t[b] < TRAS_MIN);
								bad(b == wb && cyc < wend_t + WRITE_RECOVERY);
								opn[b] = 1'b0;
								pre_t[b] = cyc;
							end
					ddr_timing_pkg::PIN_REF, ddr_timing_pkg::PIN_MRS: begin
						for (int b = 0; b < 4; b++)
							bad(opn[b] || cyc - pre_t[b] < PRECHARGE_PERIOD || cyc - act_t[b] < ACTIVATE_TO_ACTIVATE_SAME_BANK);
						if (code == ddr_timing_pkg::PIN_REF) begin
							bad(cyc - ref_t < REFRESH_CYCLE_TIME);
							ref_t = cyc;
							refs++;
						end else
							mrs_t = cyc;
					end
					default: ;
				endcase
			end
		end
	end
endmodule
`default_nettype wire
